// ==== core/pmsr_pkg.sv ====
// constants of the output-mux, slip-prevention and status register group
package pmsr_pkg;
   localparam int unsigned DATA_W = 24;
   localparam int unsigned ADDR_W = 6;

   localparam logic [5:0] ADDR_OUTPUT_PIN_CONTROL          = 6'h1B;
   localparam logic [5:0] ADDR_PHASE_DETECTOR_SLIP_CONTROL = 6'h1C;
   localparam logic [5:0] ADDR_RESERVED_A                  = 6'h1D;
   localparam logic [5:0] ADDR_THERMOMETER_CONTROL         = 6'h1E;
   localparam logic [5:0] ADDR_LOCK_SWEEP_STATUS           = 6'h1F;
   localparam logic [5:0] ADDR_RESERVED_B                  = 6'h20;
   localparam logic [5:0] ADDR_THERMOMETER_READING         = 6'h21;
   localparam logic [5:0] ADDR_RESERVED_C                  = 6'h22;

   // output pin control fields
   localparam int unsigned OPC_SEL_LSB    = 0;
   localparam int unsigned OPC_STATIC_LSB = 4;
   localparam int unsigned OPC_DRIVE_EN   = 7;
   localparam int unsigned OPC_DIS_LSB    = 8;
   localparam logic [10:0] OPC_RESET      = 11'h000;

   // slip control fields
   localparam int unsigned SLC_STEP_LSB  = 0;
   localparam int unsigned SLC_FORCE     = 4;
   localparam int unsigned SLC_RSTB      = 5;
   localparam logic [5:0]  SLC_RESET     = 6'h20;

   localparam int unsigned THC_ENABLE    = 0;
   localparam logic        THC_RESET     = 1'b0;

   // status fields
   localparam int unsigned STS_LOCK      = 0;
   localparam int unsigned STS_OVF_LSB   = 1;
   localparam int unsigned STS_SWEEP     = 5;

   localparam logic [23:0] RESERVED_A_VALUE = 24'h000000;
   localparam logic [23:0] RESERVED_B_VALUE = 24'h000020;
   localparam logic [23:0] RESERVED_C_VALUE = 24'h000000;
   localparam logic [6:0]  TEMP_CODE_RESET  = 7'h1F;

   // temperature code: floor((t+40)/17.5) evaluated as (t+40)*2/35 on whole degrees
   localparam logic signed [9:0] TEMP_OFFSET_C  = 10'sh028;
   localparam logic signed [7:0] TEMP_HIGH_C    = 8'sh53;
   localparam logic signed [7:0] TEMP_LOW_C     = -8'sh17;
   localparam logic [9:0]        TEMP_STEP_HALF = 10'h023;
   localparam logic [6:0]        TEMP_CODE_MAX  = 7'h07;
   localparam logic [6:0]        TEMP_CODE_MIN  = 7'h00;

   typedef enum logic [3:0]
   {
      SEL_STATIC    = 4'b0000,
      SEL_SWEEP     = 4'b1000,
      SEL_UNUSED    = 4'b1001,
      SEL_QUANTIZER = 4'b1010
   } pmsr_sel_t;
endpackage : pmsr_pkg

// ==== core/pmsr_sync.sv ====
// two-flop synchroniser for levels arriving from the analog and modulator side
`timescale 1ns/10ps
`default_nettype none
module pmsr_sync
#(
   parameter int unsigned WIDTH = 1
)
(
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         stage1   <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : pmsr_sync
`default_nettype wire

// ==== core/pmsr_regs.sv ====
// output pin mux, slip-prevention control, thermometer and status register group
`timescale 1ns/10ps
`default_nettype none
module pmsr_regs
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic [5:0]        reg_addr,
   input  wire logic [23:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output var  logic [23:0]       reg_rdata,
   input  wire logic              therm_sample_strobe,
   input  wire logic              slip_global_enable,
   input  wire logic              slip_auto_reset_n,
   input  wire logic              lock_in,
   input  wire logic [2:0]        overflow_in,
   input  wire logic              sweep_busy_in,
   input  wire logic [2:0]        quantizer_in,
   input  wire logic signed [7:0] temperature_in,
   output var  logic              aux_output_pin_1,
   output var  logic              aux_output_pin_2,
   output var  logic              aux_output_pin_3,
   output var  logic              aux_output_pin_1_oe,
   output var  logic              aux_output_pin_2_oe,
   output var  logic              aux_output_pin_3_oe,
   output var  logic              pfd_reset_n,
   output var  logic              charge_pump_tristate,
   output var  logic [3:0]        slip_prevention_step,
   output var  logic              slip_prevention_enable,
   output var  logic              therm_enable
);
   // whole-degree evaluation of the temperature code
   function automatic logic [6:0] temp_code(input logic signed [7:0] t);
      logic signed [9:0] shifted;
      logic [9:0]        scaled;
      shifted = 10'(t) + pmsr_pkg::TEMP_OFFSET_C;
      scaled  = 10'(unsigned'(shifted) << 1);
      if (t >= pmsr_pkg::TEMP_HIGH_C)
         temp_code = pmsr_pkg::TEMP_CODE_MAX;
      else if (t <= pmsr_pkg::TEMP_LOW_C)
         temp_code = pmsr_pkg::TEMP_CODE_MIN;
      else
         temp_code = 7'(scaled / pmsr_pkg::TEMP_STEP_HALF);
   endfunction : temp_code

   logic [16:0]       sync_bus;
   logic              lock_s;
   logic [2:0]        overflow_s;
   logic              sweep_s;
   logic [2:0]        quant_s;
   logic signed [7:0] temp_s;
   logic              auto_rstn_s;

   // analog-side levels cross together; the temperature word is only sampled on a
   // software strobe long after it settles, so a plain synchroniser is enough
   pmsr_sync
   #(
      .WIDTH (17)
   )
   u_sync
   (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in ({lock_in, overflow_in, sweep_busy_in, quantizer_in, temperature_in, slip_auto_reset_n}),
      .sync_out (sync_bus)
   );

   assign lock_s      = sync_bus[16];
   assign overflow_s  = sync_bus[15:13];
   assign sweep_s     = sync_bus[12];
   assign quant_s     = sync_bus[11:9];
   assign temp_s      = signed'(sync_bus[8:1]);
   assign auto_rstn_s = sync_bus[0];

   logic [10:0] opc;
   logic [5:0]  slc;
   logic        thc;
   logic [6:0]  temp_reading;
   logic [23:0] status_word;
   logic [10:0] next_opc;
   logic [5:0]  next_slc;
   logic        next_thc;
   logic [6:0]  next_temp_reading;
   logic [23:0] next_rdata;

   logic [3:0]  sel;
   logic [2:0]  dis;
   logic        drive_en;

   assign sel      = opc[pmsr_pkg::OPC_SEL_LSB +: 4];
   assign dis      = opc[pmsr_pkg::OPC_DIS_LSB +: 3];
   assign drive_en = opc[pmsr_pkg::OPC_DRIVE_EN];

   always_comb
   begin
      status_word = '0;
      status_word[pmsr_pkg::STS_LOCK]         = lock_s;
      status_word[pmsr_pkg::STS_OVF_LSB +: 3] = overflow_s;
      status_word[pmsr_pkg::STS_SWEEP]        = sweep_s;
   end

   // register writes; read-only and reserved locations drop the data
   always_comb
   begin
      next_opc          = opc;
      next_slc          = slc;
      next_thc          = thc;
      next_temp_reading = temp_reading;
      if (reg_wr)
      begin
         unique case (reg_addr)
            pmsr_pkg::ADDR_OUTPUT_PIN_CONTROL:          next_opc = reg_wdata[10:0];
            pmsr_pkg::ADDR_PHASE_DETECTOR_SLIP_CONTROL: next_slc = reg_wdata[5:0];
            pmsr_pkg::ADDR_THERMOMETER_CONTROL:         next_thc = reg_wdata[pmsr_pkg::THC_ENABLE];
            default:                                    next_opc = opc;
         endcase
      end
      // the strobe only counts while the sensor is powered
      if (thc && therm_sample_strobe)
         next_temp_reading = temp_code(temp_s);
   end

   // read data are captured on the read strobe and held until the next one
   always_comb
   begin
      next_rdata = reg_rdata;
      if (reg_rd)
      begin
         unique case (reg_addr)
            pmsr_pkg::ADDR_OUTPUT_PIN_CONTROL:          next_rdata = {13'h0000, opc};
            pmsr_pkg::ADDR_PHASE_DETECTOR_SLIP_CONTROL: next_rdata = {18'h00000, slc};
            pmsr_pkg::ADDR_RESERVED_A:                  next_rdata = pmsr_pkg::RESERVED_A_VALUE;
            pmsr_pkg::ADDR_THERMOMETER_CONTROL:         next_rdata = {23'h000000, thc};
            pmsr_pkg::ADDR_LOCK_SWEEP_STATUS:           next_rdata = status_word;
            pmsr_pkg::ADDR_RESERVED_B:                  next_rdata = pmsr_pkg::RESERVED_B_VALUE;
            pmsr_pkg::ADDR_THERMOMETER_READING:         next_rdata = {17'h00000, temp_reading};
            pmsr_pkg::ADDR_RESERVED_C:                  next_rdata = pmsr_pkg::RESERVED_C_VALUE;
            default:                                    next_rdata = 24'h000000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         opc          <= pmsr_pkg::OPC_RESET;
         slc          <= pmsr_pkg::SLC_RESET;
         thc          <= pmsr_pkg::THC_RESET;
         temp_reading <= pmsr_pkg::TEMP_CODE_RESET;
         reg_rdata    <= 24'h000000;
      end
      else
      begin
         opc          <= next_opc;
         slc          <= next_slc;
         thc          <= next_thc;
         temp_reading <= next_temp_reading;
         reg_rdata    <= next_rdata;
      end
   end

   // pin mux and pad enables
   logic [2:0] next_pins;
   logic [2:0] next_oe;

   always_comb
   begin
      unique case (sel)
         pmsr_pkg::SEL_STATIC:    next_pins = opc[pmsr_pkg::OPC_STATIC_LSB +: 3];
         pmsr_pkg::SEL_QUANTIZER: next_pins = quant_s;
         pmsr_pkg::SEL_SWEEP:     next_pins = {1'b0, sweep_s, 1'b0};
         // internal analog taps of the other selects do not reach this logic
         default:                 next_pins = 3'b000;
      endcase
      next_oe = drive_en ? ~dis : 3'b000;
   end

   // detector reset and slip prevention
   logic       next_pfd_reset_n;
   logic       next_slip_en;

   always_comb
   begin
      next_pfd_reset_n = slc[pmsr_pkg::SLC_FORCE] ? slc[pmsr_pkg::SLC_RSTB] : auto_rstn_s;
      next_slip_en     = slc[pmsr_pkg::SLC_RSTB] && slip_global_enable
                         && (slc[pmsr_pkg::SLC_STEP_LSB +: 4] != 4'h0);
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         aux_output_pin_1       <= 1'b0;
         aux_output_pin_2       <= 1'b0;
         aux_output_pin_3       <= 1'b0;
         aux_output_pin_1_oe    <= 1'b0;
         aux_output_pin_2_oe    <= 1'b0;
         aux_output_pin_3_oe    <= 1'b0;
         pfd_reset_n            <= 1'b0;
         charge_pump_tristate   <= 1'b1;
         slip_prevention_step   <= 4'h0;
         slip_prevention_enable <= 1'b0;
         therm_enable           <= 1'b0;
      end
      else
      begin
         aux_output_pin_1       <= next_pins[0];
         aux_output_pin_2       <= next_pins[1];
         aux_output_pin_3       <= next_pins[2];
         aux_output_pin_1_oe    <= next_oe[0];
         aux_output_pin_2_oe    <= next_oe[1];
         aux_output_pin_3_oe    <= next_oe[2];
         pfd_reset_n            <= next_pfd_reset_n;
         charge_pump_tristate   <= ~next_pfd_reset_n;
         slip_prevention_step   <= slc[pmsr_pkg::SLC_STEP_LSB +: 4];
         slip_prevention_enable <= next_slip_en;
         therm_enable           <= thc;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_static_route;
      (sel == pmsr_pkg::SEL_STATIC) |=> {aux_output_pin_3, aux_output_pin_2, aux_output_pin_1}
                                        == $past(opc[6:4]);
   endproperty
   a_static_route: assert property (p_static_route) else $error("static bits not on pins");

   property p_quant_route;
      (sel == pmsr_pkg::SEL_QUANTIZER) |=> {aux_output_pin_3, aux_output_pin_2, aux_output_pin_1}
                                           == $past(quant_s);
   endproperty
   a_quant_route: assert property (p_quant_route) else $error("quantizer bits not on pins");

   property p_unused_sel;
      (sel == pmsr_pkg::SEL_UNUSED) |=> !aux_output_pin_1 && !aux_output_pin_2 && !aux_output_pin_3;
   endproperty
   a_unused_sel: assert property (p_unused_sel) else $error("unused select drives pins");

   property p_drive_off;
      !drive_en |=> !aux_output_pin_1_oe && !aux_output_pin_2_oe && !aux_output_pin_3_oe;
   endproperty
   a_drive_off: assert property (p_drive_off) else $error("pads driven while disabled");

   property p_pad_disable;
      drive_en |=> {aux_output_pin_3_oe, aux_output_pin_2_oe, aux_output_pin_1_oe} == ~$past(dis);
   endproperty
   a_pad_disable: assert property (p_pad_disable) else $error("pad enable mismatch");

   property p_step_zero;
      (slc[3:0] == 4'h0) |=> !slip_prevention_enable;
   endproperty
   a_step_zero: assert property (p_step_zero) else $error("slip prevention on with zero step");

   property p_force_reset;
      slc[pmsr_pkg::SLC_FORCE] |=> pfd_reset_n == $past(slc[pmsr_pkg::SLC_RSTB]);
   endproperty
   a_force_reset: assert property (p_force_reset) else $error("detector reset ignores override");

   property p_auto_reset;
      !slc[pmsr_pkg::SLC_FORCE] |=> pfd_reset_n == $past(auto_rstn_s);
   endproperty
   a_auto_reset: assert property (p_auto_reset) else $error("detector reset not automatic");

   property p_pump_open;
      !pfd_reset_n |-> charge_pump_tristate;
   endproperty
   a_pump_open: assert property (p_pump_open) else $error("charge pump driven in reset");

   property p_lock_read;
      (reg_rd && reg_addr == pmsr_pkg::ADDR_LOCK_SWEEP_STATUS) |=> reg_rdata[0] == $past(lock_s)
                                                                  && reg_rdata[5] == $past(sweep_s);
   endproperty
   a_lock_read: assert property (p_lock_read) else $error("status read wrong");

   property p_temp_high;
      (thc && therm_sample_strobe && temp_s >= pmsr_pkg::TEMP_HIGH_C) |=> temp_reading == 7'h07;
   endproperty
   a_temp_high: assert property (p_temp_high) else $error("hot reading not saturated");

   property p_reserved_b;
      (reg_rd && reg_addr == pmsr_pkg::ADDR_RESERVED_B) |=> reg_rdata == 24'h000020;
   endproperty
   a_reserved_b: assert property (p_reserved_b) else $error("reserved register value wrong");

   property p_reserved_ac;
      (reg_rd && (reg_addr == pmsr_pkg::ADDR_RESERVED_A || reg_addr == pmsr_pkg::ADDR_RESERVED_C)) |=> reg_rdata == 24'h000000;
   endproperty
   a_reserved_ac: assert property (p_reserved_ac) else $error("reserved register not zero");

   property p_sweep_route;
      (sel == pmsr_pkg::SEL_SWEEP) |=> {aux_output_pin_3, aux_output_pin_2, aux_output_pin_1}
                                       == {1'b0, $past(sweep_s), 1'b0};
   endproperty
   a_sweep_route: assert property (p_sweep_route) else $error("sweep flag not on pin 2");

   property p_overflow_read;
      (reg_rd && reg_addr == pmsr_pkg::ADDR_LOCK_SWEEP_STATUS) |=> reg_rdata[3:1] == $past(overflow_s)
                                                                  && reg_rdata[4] == 1'b0;
   endproperty
   a_overflow_read: assert property (p_overflow_read) else $error("overflow flags read wrong");

   property p_temp_low;
      (thc && therm_sample_strobe && temp_s <= pmsr_pkg::TEMP_LOW_C) |=> temp_reading == 7'h00;
   endproperty
   a_temp_low: assert property (p_temp_low) else $error("cold reading not saturated");

   property p_temp_hold;
      !(thc && therm_sample_strobe) |=> $stable(temp_reading);
   endproperty
   a_temp_hold: assert property (p_temp_hold) else $error("reading changed without a sample");

   property p_step_copy;
      1'b1 |=> slip_prevention_step == $past(slc[pmsr_pkg::SLC_STEP_LSB +: 4]);
   endproperty
   a_step_copy: assert property (p_step_copy) else $error("step field not passed on");

   property p_slip_on;
      (slc[pmsr_pkg::SLC_RSTB] && slip_global_enable && slc[3:0] != 4'h0) |=> slip_prevention_enable;
   endproperty
   a_slip_on: assert property (p_slip_on) else $error("slip prevention not enabled");

   property p_slip_needs_global;
      !slip_global_enable |=> !slip_prevention_enable;
   endproperty
   a_slip_needs_global: assert property (p_slip_needs_global) else $error("slip on without master enable");

   c_quant_sel:  cover property (sel == pmsr_pkg::SEL_QUANTIZER && drive_en);
   c_temp_taken: cover property (thc && therm_sample_strobe);
   c_force:      cover property (slc[pmsr_pkg::SLC_FORCE] && !slc[pmsr_pkg::SLC_RSTB]);
   c_slip_on:    cover property (slip_prevention_enable);
   c_sweep_sel:  cover property (sel == pmsr_pkg::SEL_SWEEP && sweep_s);
endmodule : pmsr_regs
`default_nettype wire

// ==== sim/pmsr_host_model.sv ====
// host controller model that drives the register strobes, the sample pulse and the slip master enable
`timescale 1ns/10ps
`default_nettype none
module pmsr_host_model
(
   input  wire logic        clk,
   input  wire logic [23:0] reg_rdata,
   output var  logic [5:0]  reg_addr,
   output var  logic [23:0] reg_wdata,
   output var  logic        reg_wr,
   output var  logic        reg_rd,
   output var  logic        therm_sample_strobe,
   output var  logic        slip_global_enable
);
   initial
   begin
      reg_addr            = 6'h00;
      reg_wdata           = 24'h000000;
      reg_wr              = 1'b0;
      reg_rd              = 1'b0;
      therm_sample_strobe = 1'b0;
      slip_global_enable  = 1'b0;
   end

   // address and data are inverted once released so a stale value is never mistaken for a live one
   task automatic write_reg(input logic [5:0] addr, input logic [23:0] data);
      @(posedge clk);
      reg_addr  <= addr;
      reg_wdata <= data;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~addr;
      reg_wdata <= ~data;
   endtask : write_reg

   task automatic read_reg(input logic [5:0] addr, output logic [23:0] data);
      @(posedge clk);
      reg_addr <= addr;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~addr;
      @(posedge clk);
      data = reg_rdata;
   endtask : read_reg

   // the sample pulse only counts once the sensor enable is written first
   task automatic sample_pulse();
      @(posedge clk);
      therm_sample_strobe <= 1'b1;
      @(posedge clk);
      therm_sample_strobe <= 1'b0;
   endtask : sample_pulse

   task automatic set_global(input logic en);
      @(posedge clk);
      slip_global_enable <= en;
   endtask : set_global
endmodule : pmsr_host_model
`default_nettype wire

// ==== sim/pll_output_mux_status_regs_tb.sv ====
// self-checking bench for the output-mux, slip-prevention and status register group
`timescale 1ns/10ps
`default_nettype none
module pll_output_mux_status_regs_tb;
   logic clk, sys_rst, therm_sample_strobe, slip_global_enable, slip_auto_reset_n, lock_in, sweep_busy_in;
   logic reg_wr, reg_rd, pin1, pin2, pin3, oe1, oe2, oe3, pfd_reset_n, charge_pump_tristate;
   logic slip_prevention_enable, therm_enable;
   logic [5:0] reg_addr;
   logic [23:0] reg_wdata, reg_rdata, rd;
   logic [2:0] overflow_in, quantizer_in, pins, oe;
   logic [3:0] slip_prevention_step;
   logic signed [7:0] temperature_in;
   int n_errors, check_count;

   assign pins = {pin3, pin2, pin1};
   assign oe   = {oe3, oe2, oe1};

   pmsr_host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .therm_sample_strobe(therm_sample_strobe),
      .slip_global_enable(slip_global_enable));

   pmsr_regs uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .therm_sample_strobe(therm_sample_strobe),
      .slip_global_enable(slip_global_enable), .slip_auto_reset_n(slip_auto_reset_n), .lock_in(lock_in),
      .overflow_in(overflow_in), .sweep_busy_in(sweep_busy_in), .quantizer_in(quantizer_in),
      .temperature_in(temperature_in), .aux_output_pin_1(pin1), .aux_output_pin_2(pin2),
      .aux_output_pin_3(pin3), .aux_output_pin_1_oe(oe1), .aux_output_pin_2_oe(oe2),
      .aux_output_pin_3_oe(oe3), .pfd_reset_n(pfd_reset_n), .charge_pump_tristate(charge_pump_tristate),
      .slip_prevention_step(slip_prevention_step), .slip_prevention_enable(slip_prevention_enable),
      .therm_enable(therm_enable));

   always #4 clk = ~clk;

   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [5:0] addr, input logic [23:0] exp);
      host.read_reg(addr, rd);
      chk(rd, exp, "register read");
   endtask : rd_chk

   // covers two synchroniser flops plus output register with margin
   task automatic settle();
      repeat (5) @(posedge clk);
   endtask : settle

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize

   task automatic test_reset();
      logic [5:0]  addrs [9] = '{6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h3F};
      logic [23:0] exps [9] = '{24'h0, 24'h20, 24'h0, 24'h0, 24'h0, 24'h20, 24'h1F, 24'h0, 24'h0};
      chk(24'(oe), 24'h0, "oe after reset");
      chk(24'(pfd_reset_n), 24'h000001, "detector out of reset");
      chk(24'(charge_pump_tristate), 24'h000000, "pump driven after reset");
      chk(24'(therm_enable), 24'h0, "thermometer off");
      for (int i = 0; i < 9; i++)
         rd_chk(addrs[i], exps[i]);
   endtask : test_reset

   task automatic test_reserved();
      logic [5:0]  addrs [5] = '{6'h1D, 6'h1F, 6'h20, 6'h21, 6'h22};
      logic [23:0] exps [5] = '{24'h0, 24'h0, 24'h20, 24'h1F, 24'h0};
      for (int i = 0; i < 5; i++)
         host.write_reg(addrs[i], 24'hFFFFFF);
      for (int i = 0; i < 5; i++)
         rd_chk(addrs[i], exps[i]);
      host.write_reg(pmsr_pkg::ADDR_OUTPUT_PIN_CONTROL, 24'hFFFFFF);
      rd_chk(pmsr_pkg::ADDR_OUTPUT_PIN_CONTROL, 24'h0007FF);
      host.write_reg(pmsr_pkg::ADDR_PHASE_DETECTOR_SLIP_CONTROL, 24'hFFFFFF);
      rd_chk(pmsr_pkg::ADDR_PHASE_DETECTOR_SLIP_CONTROL, 24'h00003F);
   endtask : test_reserved

   task automatic pin_case(input logic [23:0] val, input logic [2:0] ep, input logic [2:0] eo);
      host.write_reg(pmsr_pkg::ADDR_OUTPUT_PIN_CONTROL, val);
      settle();
      chk(24'(pins), 24'(ep), "pin data");
      chk(24'(oe), 24'(eo), "pin enables");
   endtask : pin_case

   task automatic test_pins();
      quantizer_in <= 3'b110;
      pin_case(24'h0000D0, 3'b101, 3'b111);
      pin_case(24'h0005D0, 3'b101, 3'b010);
      pin_case(24'h000350, 3'b101, 3'b000);
      pin_case(24'h00068A, 3'b110, 3'b001);
      pin_case(24'h0000D9, 3'b000, 3'b111);
      sweep_busy_in <= 1'b1;
      pin_case(24'h0000D8, 3'b010, 3'b111);
      sweep_busy_in <= 1'b0;
   endtask : test_pins

   task automatic slip_case(input logic [23:0] val, input logic ep, input logic [3:0] es, input logic ee);
      host.write_reg(pmsr_pkg::ADDR_PHASE_DETECTOR_SLIP_CONTROL, val);
      settle();
      chk(24'(pfd_reset_n), 24'(ep), "detector reset");
      chk(24'(charge_pump_tristate), 24'(!ep), "charge pump");
      chk(24'(slip_prevention_step), 24'(es), "step");
      chk(24'(slip_prevention_enable), 24'(ee), "slip enable");
   endtask : slip_case

   task automatic test_slip();
      host.set_global(1'b1);
      slip_case(24'h000010, 1'b0, 4'h0, 1'b0);
      slip_case(24'h000039, 1'b1, 4'h9, 1'b1);
      slip_auto_reset_n <= 1'b0;
      slip_case(24'h00002D, 1'b0, 4'hD, 1'b1);
      slip_auto_reset_n <= 1'b1;
      slip_case(24'h00000D, 1'b1, 4'hD, 1'b0);
      slip_case(24'h000020, 1'b1, 4'h0, 1'b0);
      host.set_global(1'b0);
      slip_case(24'h000025, 1'b1, 4'h5, 1'b0);
   endtask : test_slip

   task automatic test_status();
      lock_in       <= 1'b1;
      overflow_in   <= 3'b101;
      sweep_busy_in <= 1'b1;
      settle();
      rd_chk(pmsr_pkg::ADDR_LOCK_SWEEP_STATUS, 24'h00002B);
      lock_in       <= 1'b0;
      overflow_in   <= 3'b010;
      sweep_busy_in <= 1'b0;
      settle();
      rd_chk(pmsr_pkg::ADDR_LOCK_SWEEP_STATUS, 24'h000004);
   endtask : test_status

   task automatic test_temp();
      logic signed [7:0] temps [7] = '{8'sh53, 8'sh52, 8'shEA, 8'shE9, 8'sh19, 8'sh64, 8'shD8};
      logic [23:0]       codes [7] = '{24'h7, 24'h6, 24'h1, 24'h0, 24'h3, 24'h7, 24'h0};
      temperature_in <= 8'sh19;
      settle();
      host.sample_pulse();
      rd_chk(pmsr_pkg::ADDR_THERMOMETER_READING, 24'h00001F);
      host.write_reg(pmsr_pkg::ADDR_THERMOMETER_CONTROL, 24'h000001);
      settle();
      chk(24'(therm_enable), 24'h1, "thermometer enable");
      for (int i = 0; i < 7; i++)
      begin
         temperature_in <= temps[i];
         settle();
         host.sample_pulse();
         rd_chk(pmsr_pkg::ADDR_THERMOMETER_READING, codes[i]);
      end
   endtask : test_temp

   initial
   begin
      clk               = 1'b0;
      sys_rst           = 1'b1;
      slip_auto_reset_n = 1'b1;
      lock_in           = 1'b0;
      overflow_in       = 3'b000;
      sweep_busy_in     = 1'b0;
      quantizer_in      = 3'b000;
      temperature_in    = 8'sh00;
      n_errors          = 0;
      check_count       = 0;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      settle();
      test_reset();
      test_reserved();
      test_pins();
      test_slip();
      test_status();
      test_temp();
      summarize();
   end

   // guards against a stuck run; the whole sequence needs far fewer cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      summarize();
   end
endmodule : pll_output_mux_status_regs_tb
`default_nettype wire
